// File: shared/upp_regs.vh
`ifndef UPP_REGS_VH
`define UPP_REGS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define UPP_SFR_DATA      8'h90
`define UPP_SFR_DIR       8'h91
`define UPP_SFR_TCTL      8'h88
`define UPP_XR_CFG_A      16'hFF90
`define UPP_XR_CFG_B      16'hFF91
`define UPP_XR_CFG_C      16'hFF92
`define UPP_XR_CFG_D      16'hFF93

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define UPP_SEL_LO_MSB    2
`define UPP_SEL_LO_LSB    0
`define UPP_SEL_HI_MSB    6
`define UPP_SEL_HI_LSB    4
`define UPP_TCTL_IT0      0
`define UPP_TCTL_IT1      2
`define UPP_CFG_COUNT     4
`define UPP_DIR_RST       8'hFF
`define UPP_CFG_RST       8'h00
`define UPP_DATA_RST      8'hFF

// ----------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------
`define UPP_SEL_T0        3'h2
`define UPP_SEL_T1        3'h3
`define UPP_SEL_I0_HI     3'h4
`define UPP_SEL_I1_HI     3'h5
`define UPP_SEL_I0_LO     3'h6
`define UPP_SEL_I1_LO     3'h7

`endif

// File: rtl/upp_user_pin_port.v
`timescale 1ns/100ps
`default_nettype none
`include "upp_regs.vh"

module upp_user_pin_port #(
  parameter NPINS = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Special function register port
  input  wire [7:0]       sfrAddr,
  input  wire             sfrWr,
  input  wire [7:0]       sfrWdata,
  output reg  [7:0]       sfrRdata,
  // External memory mapped register port
  input  wire [15:0]      xrAddr,
  input  wire             xrWr,
  input  wire [7:0]       xrWdata,
  output reg  [7:0]       xrRdata,
  // Interrupt flag service
  input  wire             irq0Ack,
  input  wire             irq1Ack,
  // Pins
  input  wire [NPINS-1:0] pinIn,
  output reg  [NPINS-1:0] pinOut,
  output reg  [NPINS-1:0] pinOe,
  output reg  [NPINS-1:0] pinPullUp,
  // Internal resources
  output reg              timer0GateClock,
  output reg              timer1GateClock,
  output reg              extIrq0,
  output reg              extIrq1
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [NPINS-1:0] syncA_r;
  reg [NPINS-1:0] syncB_r;
  reg [7:0]       dataReg_r;
  reg [7:0]       dirReg_r;
  reg             pullEn_r;
  reg             it0_r;
  reg             it1_r;
  reg [7:0]       cfg_r [0:`UPP_CFG_COUNT-1];
  reg             irq0Prev_r;
  reg             irq1Prev_r;
  reg             irq0Flag_r;
  reg             irq1Flag_r;

  localparam [15:0] CFG_BASE = `UPP_XR_CFG_A;

  wire [2:0]       sel [0:NPINS-1];
  wire [NPINS-1:0] hitT0;
  wire [NPINS-1:0] hitT1;
  wire [NPINS-1:0] hitI0;
  wire [NPINS-1:0] hitI1;
  wire             cfgHit = (xrAddr[15:2] == CFG_BASE[15:2]);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flip-flops on every pin; only the second stage is used.
  always @(posedge clk) begin
    if (rst) begin
      syncA_r <= {NPINS{1'b1}};
      syncB_r <= {NPINS{1'b1}};
    end else begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  integer k;
  always @(posedge clk) begin
    if (rst) begin
      dataReg_r <= `UPP_DATA_RST;
      dirReg_r  <= `UPP_DIR_RST;
      pullEn_r  <= 1'b1;
      it0_r     <= 1'b0;
      it1_r     <= 1'b0;
      for (k = 0; k < `UPP_CFG_COUNT; k = k + 1) begin
        cfg_r[k] <= `UPP_CFG_RST;
      end
    end else begin
      if (sfrWr && sfrAddr == `UPP_SFR_DATA) begin
        dataReg_r <= sfrWdata;
      end
      // Any direction write, whatever its value, ends the reset pull-ups for good.
      if (sfrWr && sfrAddr == `UPP_SFR_DIR) begin
        dirReg_r <= sfrWdata;
        pullEn_r <= 1'b0;
      end
      // Only the two interrupt-type bits of a timer control write are kept here.
      if (sfrWr && sfrAddr == `UPP_SFR_TCTL) begin
        it0_r <= sfrWdata[`UPP_TCTL_IT0];
        it1_r <= sfrWdata[`UPP_TCTL_IT1];
      end
      if (xrWr && cfgHit) begin
        cfg_r[xrAddr[1:0]] <= {1'b0, xrWdata[`UPP_SEL_HI_MSB:`UPP_SEL_HI_LSB], 1'b0,
                               xrWdata[`UPP_SEL_LO_MSB:`UPP_SEL_LO_LSB]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-pin routing
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : gPin
      // Even pins take the low field, odd pins the high field.
      if (g % 2 == 0) begin : gLo
        assign sel[g] = cfg_r[g/2][`UPP_SEL_LO_MSB:`UPP_SEL_LO_LSB];
      end else begin : gHi
        assign sel[g] = cfg_r[g/2][`UPP_SEL_HI_MSB:`UPP_SEL_HI_LSB];
      end
      assign hitT0[g] = (sel[g] == `UPP_SEL_T0) & syncB_r[g];
      assign hitT1[g] = (sel[g] == `UPP_SEL_T1) & syncB_r[g];
      // Low-active pins are inverted so every hit is high-true at the OR.
      assign hitI0[g] = ((sel[g] == `UPP_SEL_I0_HI) & syncB_r[g]) |
                        ((sel[g] == `UPP_SEL_I0_LO) & ~syncB_r[g]);
      assign hitI1[g] = ((sel[g] == `UPP_SEL_I1_HI) & syncB_r[g]) |
                        ((sel[g] == `UPP_SEL_I1_LO) & ~syncB_r[g]);
    end
  endgenerate

  wire irq0Lvl = |hitI0;
  wire irq1Lvl = |hitI1;

  // ----------------------------------------------------------------
  // Interrupt edge flags and outputs
  // ----------------------------------------------------------------
  wire irq0Edge     = irq0Lvl & ~irq0Prev_r;
  wire irq1Edge     = irq1Lvl & ~irq1Prev_r;
  // A new edge in the acknowledge cycle keeps the flag set.
  wire irq0Flag_nxt = irq0Edge | (irq0Flag_r & ~irq0Ack);
  wire irq1Flag_nxt = irq1Edge | (irq1Flag_r & ~irq1Ack);

  always @(posedge clk) begin
    if (rst) begin
      irq0Prev_r      <= 1'b0;
      irq1Prev_r      <= 1'b0;
      irq0Flag_r      <= 1'b0;
      irq1Flag_r      <= 1'b0;
      timer0GateClock <= 1'b0;
      timer1GateClock <= 1'b0;
      extIrq0         <= 1'b0;
      extIrq1         <= 1'b0;
    end else begin
      irq0Prev_r      <= irq0Lvl;
      irq1Prev_r      <= irq1Lvl;
      irq0Flag_r      <= irq0Flag_nxt;
      irq1Flag_r      <= irq1Flag_nxt;
      timer0GateClock <= |hitT0;
      timer1GateClock <= |hitT1;
      // Edge mode shows the pending flag, so the CPU sees it until it acknowledges.
      extIrq0         <= it0_r ? irq0Flag_nxt : irq0Lvl;
      extIrq1         <= it1_r ? irq1Flag_nxt : irq1Lvl;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pull-ups follow the input pins only until the first direction write.
  always @(posedge clk) begin
    if (rst) begin
      pinOut    <= {NPINS{1'b0}};
      pinOe     <= {NPINS{1'b0}};
      pinPullUp <= {NPINS{1'b1}};
    end else begin
      pinOut    <= dataReg_r[NPINS-1:0];
      pinOe     <= ~dirReg_r[NPINS-1:0];
      pinPullUp <= pullEn_r ? ~pinOe : {NPINS{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      sfrRdata <= 8'h00;
      xrRdata  <= 8'h00;
    end else begin
      // Reads are registered, so data appears one clock after the address.
      case (sfrAddr)
        `UPP_SFR_DATA: sfrRdata <= syncB_r;
        `UPP_SFR_DIR:  sfrRdata <= dirReg_r;
        default:       sfrRdata <= 8'h00;
      endcase
      if (cfgHit) begin
        xrRdata <= cfg_r[xrAddr[1:0]];
      end else begin
        xrRdata <= 8'h00;
      end
    end
  end

endmodule // upp_user_pin_port

`default_nettype wire

// File: bench/upp_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module upp_board_model (
  input wire [7:0] pinOut, pinOe, pinPullUp, boardEn, boardVal,
  output wire [7:0] pinIn
);
  // A released pin with no pull-up and no board drive shows the inverse of pinOut, never a lucky settle.
  assign pinIn = pinOe & pinOut | ~pinOe & (boardEn & boardVal | ~boardEn & (pinPullUp | ~pinOut));
endmodule // upp_board_model
`default_nettype wire

// File: bench/upp_user_pin_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module upp_user_pin_port_sva #(parameter NPINS = 8) (
  input wire clk, rst, sfrWr, xrWr,
  input wire [7:0] sfrAddr, sfrWdata, sfrRdata, xrWdata, xrRdata,
  input wire [15:0] xrAddr,
  input wire [NPINS-1:0] pinOut, pinOe, pinPullUp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dw; sfrWr && sfrAddr == 8'h91; endsequence
  sequence s_cwr; xrWr && xrAddr == 16'hFF93 ##1 xrAddr == 16'hFF93; endsequence
  property p_oe; s_dw |-> ##2 pinOe == ~$past(sfrWdata, 2); endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
  property p_out; sfrWr && sfrAddr == 8'h90 |-> ##2 pinOut == $past(sfrWdata, 2); endproperty
  a_out: assert property (p_out) else $error("bad output");
  property p_pu; s_dw |-> ##[1:3] pinPullUp == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up kept");
  property p_puh; pinPullUp == 8'h00 |=> pinPullUp == 8'h00; endproperty
  a_puh: assert property (p_puh) else $error("pull-up back");
  property p_drd; s_dw ##1 sfrAddr == 8'h91 |=> sfrRdata == $past(sfrWdata, 2); endproperty
  a_drd: assert property (p_drd) else $error("bad dir read");
  property p_crd; s_cwr |=> xrRdata == ($past(xrWdata, 2) & 8'h77); endproperty
  a_crd: assert property (p_crd) else $error("bad route read");
  property p_sgap; !(sfrAddr inside {8'h90, 8'h91}) |=> sfrRdata == 8'h00; endproperty
  a_sgap: assert property (p_sgap) else $error("gap read");
  property p_xgap; !(xrAddr inside {[16'hFF90:16'hFF93]}) |=> xrRdata == 8'h00; endproperty
  a_xgap: assert property (p_xgap) else $error("gap read");
endmodule // upp_user_pin_port_sva
bind upp_user_pin_port upp_user_pin_port_sva #(.NPINS(NPINS)) sva (.clk, .rst, .sfrWr, .xrWr, .sfrAddr,
  .sfrWdata, .sfrRdata, .xrWdata, .xrRdata, .xrAddr, .pinOut, .pinOe, .pinPullUp);
`default_nettype wire

// File: bench/upp_user_pin_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module upp_user_pin_port_test;
  reg clk = 1'h0, rst = 1'h1, sfrWr, xrWr, ack;
  reg [7:0] sfrAddr, sfrWdata, xrWdata, boardEn, boardVal;
  reg [15:0] xrAddr;
  wire [7:0] sfrRdata, xrRdata, pinIn, pinOut, pinOe, pinPullUp;
  wire t0, t1, i0, i1;
  integer error_cnt = 0, checks = 0, c;
  always #12.5 clk = ~clk;
  upp_user_pin_port upp_user_pin_port_inst (.clk, .rst, .sfrAddr, .sfrWr, .sfrWdata, .sfrRdata, .xrAddr,
    .xrWr, .xrWdata, .xrRdata, .irq0Ack(ack), .irq1Ack(ack), .pinIn, .pinOut, .pinOe, .pinPullUp,
    .timer0GateClock(t0), .timer1GateClock(t1), .extIrq0(i0), .extIrq1(i1));
  upp_board_model upp_board_model_inst (.pinOut, .pinOe, .pinPullUp, .boardEn, .boardVal, .pinIn);
  task chk(input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task acc(input x, input w, input [15:0] a, input [7:0] d);
    @(negedge clk);
    {xrWr, sfrWr, xrAddr, sfrAddr, xrWdata, sfrWdata} = {x & w, ~x & w, a, a[7:0], d, d};
    @(negedge clk);
    {xrWr, sfrWr} = 2'h0;
    if (!w) chk(x ? xrRdata : sfrRdata, d);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    {sfrWr, xrWr, ack, sfrAddr, sfrWdata, xrWdata, boardEn, boardVal, xrAddr} = '0;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk({pinOe, pinPullUp}, 16'h00FF);
    acc(0, 0, 16'h0091, 8'hFF);
    acc(1, 0, 16'hFF93, 8'h00);
    acc(0, 0, 16'h0090, 8'hFF);
    boardEn = 8'hFF;
    acc(1, 1, 16'hFF90, 8'h03);
    acc(0, 1, 16'h0088, 8'h00);
    for (c = 0; c < 16; c = c + 1) begin
      acc(1, 1, 16'hFF93, c[3:1]);
      boardVal = {1'h0, c[0], 6'h00};
      repeat (4) @(negedge clk);
      chk({t0, t1, i0, i1}, {c == 5, c == 7, c == 9 || c == 12, c == 11 || c == 14});
    end
    acc(1, 1, 16'hFF93, 8'h22);
    boardVal = 8'h81;
    repeat (4) @(negedge clk);
    chk({t0, t1}, 2'h3);
    boardVal = 8'h40;
    repeat (4) @(negedge clk);
    chk({t0, t1}, 2'h2);
    boardVal = 8'h00;
    repeat (4) @(negedge clk);
    chk({t0, t1}, 2'h0);
    acc(1, 1, 16'hFF93, 8'h54);
    ack = 1'h1;
    @(negedge clk);
    ack = 1'h0;
    acc(0, 1, 16'h0088, 8'h05);
    repeat (2) @(negedge clk);
    chk({i0, i1}, 2'h0);
    boardVal = 8'hC0;
    repeat (4) @(negedge clk);
    chk({i0, i1}, 2'h3);
    ack = 1'h1;
    @(negedge clk);
    ack = 1'h0;
    repeat (2) @(negedge clk);
    chk({i0, i1}, 2'h0);
    acc(1, 1, 16'hFF93, 8'h76);
    boardVal = 8'h00;
    repeat (4) @(negedge clk);
    chk({i0, i1}, 2'h3);
    acc(0, 1, 16'h0091, 8'hF0);
    acc(0, 1, 16'h0090, 8'hA5);
    boardVal = 8'hC3;
    repeat (3) @(negedge clk);
    chk({pinOe, pinPullUp}, 16'h0F00);
    chk(pinOut, 16'h00A5);
    acc(0, 0, 16'h0090, 8'hC5);
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk({pinOe, pinPullUp}, 16'h00FF);
    acc(0, 0, 16'h0091, 8'hFF);
    acc(1, 0, 16'hFF93, 8'h00);
    tally_and_finish;
  end
endmodule // upp_user_pin_port_test
`default_nettype wire
